// >>> arsq_consts.svh
`ifndef ARSQ_CONSTS_SVH
`define ARSQ_CONSTS_SVH
// register offsets (byte addresses, one aligned word each)
`define ARSQ_OFF_CTRL 12'h000
`define ARSQ_OFF_STATUS 12'h004
`define ARSQ_OFF_IRQ_STAT 12'h008
`define ARSQ_OFF_IRQ_MASK 12'h00c
`define ARSQ_OFF_TRIM 12'h010
// control register fields
`define ARSQ_CTRL_SUPPLY_OK 0
`define ARSQ_CTRL_RESET 32'h0000_0000
// interrupt bit positions
`define ARSQ_IRQ_STATE_CHG 0
`define ARSQ_IRQ_FAULT 1
`define ARSQ_IRQ_WAKE_BLOCKED 2
`define ARSQ_IRQ_W 3
// trim codes, in units of 0.1 v
`define ARSQ_TRIM_0 2'h0
`define ARSQ_TRIM_1 2'h1
`define ARSQ_TRIM_2 2'h2
// terminator step in units of 0.05 v equals the rail-1 step in 0.1 v
`define ARSQ_SYNC_STAGES 2
`endif

// >>> arsq_pkg.sv
package arsq_pkg;
   // sequencer states, one-hot
   typedef enum logic [4:0] {
      ARSQ_MECH_OFF = 5'h01,
      ARSQ_SOFT_OFF_DUAL_OFF = 5'h02,
      ARSQ_SOFT_OFF_DUAL_ON = 5'h04,
      ARSQ_FULL_POWER = 5'h08,
      ARSQ_SUSPEND = 5'h10
   } arsq_state_t;
   // three-level strap reading
   typedef enum logic [1:0] {
      ARSQ_STRAP_LOW = 2'h0,
      ARSQ_STRAP_OPEN = 2'h1,
      ARSQ_STRAP_HIGH = 2'h2
   } arsq_strap_t;
endpackage : arsq_pkg

// >>> arsq_sync.sv
// two-flop synchroniser, one per bit
module arsq_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // data
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_ff;

   initial begin
      if (WIDTH < 1) $error("arsq_sync: WIDTH must be at least 1");
   end

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_ff <= INIT;
         q <= INIT;
      end else begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end
endmodule // arsq_sync

// >>> arsq_trim.sv
`include "arsq_consts.svh"
// decodes mode and trim straps into output steps
module arsq_trim
   import arsq_pkg::*;
(
   input wire logic mode_b,
   input wire arsq_strap_t trim_strap,
   output logic [1:0] rail1_step,
   output logic [1:0] rail2_step,
   output logic [1:0] term_step
);
   // mode a rises low->open->high, mode b rises high->open->low
   function automatic logic [1:0] step_of(input arsq_strap_t s, input logic inv);
      logic [1:0] r;
      r = `ARSQ_TRIM_0;
      case (s)
         ARSQ_STRAP_LOW: r = inv ? `ARSQ_TRIM_2 : `ARSQ_TRIM_0;
         ARSQ_STRAP_OPEN: r = `ARSQ_TRIM_1;
         ARSQ_STRAP_HIGH: r = inv ? `ARSQ_TRIM_0 : `ARSQ_TRIM_2;
         default: r = `ARSQ_TRIM_0;
      endcase
      return r;
   endfunction

   always_comb begin
      rail1_step = step_of(trim_strap, mode_b); // [RULE2]
      rail2_step = mode_b ? step_of(trim_strap, 1'b1) : `ARSQ_TRIM_0; // [RULE2]
      // terminator is half of rail 1: same code in half-size units
      term_step = mode_b ? `ARSQ_TRIM_0 : rail1_step; // [RULE3]
   end
endmodule // arsq_trim

// >>> arsq_sequencer.sv
`include "arsq_consts.svh"
// Notes on behaviour
// [RULE1] mode strap alone picks mode, low is a
// [RULE2] trim strap gives 0, 0.1, 0.2 v step
// [RULE3] terminator target tracks half trimmed rail 1
// [RULE4] leave mechanical off once supply qualified
// [RULE5] dual on via enable low or both lines high
// [RULE6] dual on returns off when enable goes high
// [RULE7] both lines high moves dual on to full
// [RULE8] system requests suspend or soft off from full
// [RULE9] suspend wakes only with power good high
// [RULE10] outputs follow the per-state output map
// [RULE11] undervoltage monitor only in full and suspend
// [RULE12] wake waits for external power good input
// [RULE13] pull power good low on monitored fault
// [RULE14] ramped transitions wait for soft-start done
// [RULE15] mode b starts rail 3 before rail 1
// [RULE16] mode a terminator slews at half rate
// [RULE17] state lines are active low, idle high
// [RULE18] inputs synchronised before the state machine; SUPPLY_QUALIFIED goes in unsynchronised
// [RULE19] ramp done is one comparator, restarted each time
module arsq_sequencer
   import arsq_pkg::*;
(
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // system state lines, active low
   input wire logic SLEEP_LINE_N,
   input wire logic SOFT_OFF_LINE_N,
   input wire logic DUAL_RAIL_ENABLE_N,
   // straps
   input wire logic MODE_STRAP,
   input wire logic [1:0] TRIM_STRAP,
   // analog feedback
   input wire logic SUPPLY_QUALIFIED,
   input wire logic RAMP_DONE,
   input wire logic [2:0] RAIL_UNDERVOLTAGE,
   input wire logic OVER_CURRENT,
   // open-drain power-good line
   input wire logic POWER_GOOD_LINE_IN,
   output logic POWER_GOOD_LINE_OUT,
   output logic POWER_GOOD_LINE_OE,
   // power outputs
   output logic STANDBY_GATE_DRIVE,
   output logic MAIN_GATE_DRIVE,
   output logic LINEAR_RAIL_1,
   output logic LINEAR_RAIL_2,
   output logic LINEAR_RAIL_3,
   output logic BUS_TERMINATOR,
   output logic LINEAR_UNDERVOLTAGE_MONITOR,
   output logic RAMP_RESTART,
   output logic TERM_HALF_SLEW,
   output logic RAIL3_EARLY,
   output logic [1:0] RAIL1_TRIM,
   output logic [1:0] RAIL2_TRIM,
   output logic [1:0] TERM_TRIM,
   // interrupt
   output logic IRQ
);
   arsq_state_t state_ff, nxt_state;
   logic [3:0] lines_s;
   logic sleep_s, soft_off_s, dual_en_s, pg_s;
   logic mode_b_ff, straps_taken_ff;
   arsq_strap_t trim_ff;
   logic [1:0] r1_step, r2_step, t_step;
   logic [31:0] ctrl_ff;
   logic [`ARSQ_IRQ_W-1:0] irq_stat_ff, irq_mask_ff, ev;
   logic ramping_ff, fault;
   logic apb_wr, apb_rd;

   // every state line and the comparator pass two flops first [RULE18]
   arsq_sync #(.WIDTH(4), .INIT(4'hf)) u_sync_lines (
      .clk(CLK_SYS),
      .rst(RST),
      .d({SLEEP_LINE_N, SOFT_OFF_LINE_N, DUAL_RAIL_ENABLE_N, POWER_GOOD_LINE_IN}),
      .q(lines_s)
   );
   // undriven lines idle high, so reset value is high too [RULE17]
   assign sleep_s = lines_s[3];
   assign soft_off_s = lines_s[2];
   assign dual_en_s = lines_s[1];
   assign pg_s = lines_s[0];

   logic ramp_s;
   arsq_sync #(.WIDTH(1), .INIT(1'b0)) u_sync_ramp (
      .clk(CLK_SYS),
      .rst(RST),
      .d(RAMP_DONE),
      .q(ramp_s) // [RULE19]
   );

   // straps are caught once after reset release, never under reset
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         straps_taken_ff <= 1'b0;
         mode_b_ff <= 1'b0;
         trim_ff <= ARSQ_STRAP_LOW;
      end else if (!straps_taken_ff) begin
         straps_taken_ff <= 1'b1;
         mode_b_ff <= MODE_STRAP; // low selects terminator mode [RULE1]
         trim_ff <= arsq_strap_t'(TRIM_STRAP);
      end
   end

   arsq_trim u_trim (
      .mode_b(mode_b_ff),
      .trim_strap(trim_ff),
      .rail1_step(r1_step),
      .rail2_step(r2_step),
      .term_step(t_step)
   );

   // trim outputs registered
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         RAIL1_TRIM <= `ARSQ_TRIM_0;
         RAIL2_TRIM <= `ARSQ_TRIM_0;
         TERM_TRIM <= `ARSQ_TRIM_0;
      end else begin
         RAIL1_TRIM <= r1_step; // [RULE2]
         RAIL2_TRIM <= r2_step; // [RULE2]
         TERM_TRIM <= t_step; // [RULE3]
      end
   end

   // a fault counts only on rails that are being watched
   assign fault = LINEAR_UNDERVOLTAGE_MONITOR & OVER_CURRENT &
      (mode_b_ff ? (|RAIL_UNDERVOLTAGE) : RAIL_UNDERVOLTAGE[0]); // [RULE11]

   // next-state logic; straps must be settled before leaving mech off
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ARSQ_MECH_OFF: begin
            if (straps_taken_ff && (SUPPLY_QUALIFIED || ctrl_ff[`ARSQ_CTRL_SUPPLY_OK]))
               nxt_state = ARSQ_SOFT_OFF_DUAL_OFF; // [RULE4]
         end
         ARSQ_SOFT_OFF_DUAL_OFF: begin
            // ramp must reach its limit before entering dual on [RULE14]
            if ((!dual_en_s || (sleep_s && soft_off_s)) && ramping_ff && ramp_s)
               nxt_state = ARSQ_SOFT_OFF_DUAL_ON; // [RULE5]
         end
         ARSQ_SOFT_OFF_DUAL_ON: begin
            if (sleep_s && soft_off_s) begin
               if (ramping_ff && ramp_s)
                  nxt_state = ARSQ_FULL_POWER; // [RULE7] [RULE14]
            end else if (dual_en_s) begin
               nxt_state = ARSQ_SOFT_OFF_DUAL_OFF; // [RULE6]
            end
         end
         ARSQ_FULL_POWER: begin
            // system side drives these requests [RULE8]
            if (!soft_off_s)
               nxt_state = ARSQ_SOFT_OFF_DUAL_OFF;
            else if (!sleep_s)
               nxt_state = ARSQ_SUSPEND;
         end
         ARSQ_SUSPEND: begin
            if (!soft_off_s)
               nxt_state = ARSQ_SOFT_OFF_DUAL_OFF; // [RULE9]
            else if (sleep_s && pg_s)
               nxt_state = ARSQ_FULL_POWER; // [RULE9] [RULE12]
         end
         default: nxt_state = ARSQ_MECH_OFF;
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST)
         state_ff <= ARSQ_MECH_OFF;
      else
         state_ff <= nxt_state;
   end

   // ramp control: restart pulse at start of each ramped transition
   // the pulse discharges the soft-start node, so done must drop first
   logic want_ramp;
   always_comb begin
      want_ramp = 1'b0;
      if (state_ff == ARSQ_SOFT_OFF_DUAL_OFF)
         want_ramp = !dual_en_s || (sleep_s && soft_off_s);
      else if (state_ff == ARSQ_SOFT_OFF_DUAL_ON)
         want_ramp = sleep_s && soft_off_s;
   end

   logic ramp_seen_low_ff;
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         ramping_ff <= 1'b0;
         ramp_seen_low_ff <= 1'b0;
         RAMP_RESTART <= 1'b0;
      end else begin
         RAMP_RESTART <= 1'b0;
         if (nxt_state != state_ff || !want_ramp) begin
            ramping_ff <= 1'b0;
            ramp_seen_low_ff <= 1'b0;
         end else if (!ramp_seen_low_ff) begin
            RAMP_RESTART <= 1'b1; // [RULE19]
            if (!ramp_s)
               ramp_seen_low_ff <= 1'b1;
         end else begin
            ramping_ff <= 1'b1; // done now means this ramp finished
         end
      end
   end

   // output map per state
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         STANDBY_GATE_DRIVE <= 1'b0;
         MAIN_GATE_DRIVE <= 1'b0;
         LINEAR_RAIL_1 <= 1'b0;
         LINEAR_RAIL_2 <= 1'b0;
         LINEAR_RAIL_3 <= 1'b0;
         BUS_TERMINATOR <= 1'b0;
         LINEAR_UNDERVOLTAGE_MONITOR <= 1'b0;
      end else begin
         STANDBY_GATE_DRIVE <= (nxt_state == ARSQ_SOFT_OFF_DUAL_ON) ||
            (nxt_state == ARSQ_SUSPEND); // [RULE10]
         MAIN_GATE_DRIVE <= (nxt_state == ARSQ_FULL_POWER); // [RULE10]
         LINEAR_RAIL_1 <= (nxt_state == ARSQ_FULL_POWER) || (nxt_state == ARSQ_SUSPEND);
         LINEAR_RAIL_2 <= mode_b_ff &&
            ((nxt_state == ARSQ_FULL_POWER) || (nxt_state == ARSQ_SUSPEND));
         LINEAR_RAIL_3 <= mode_b_ff &&
            ((nxt_state == ARSQ_FULL_POWER) || (nxt_state == ARSQ_SUSPEND)); // [RULE10]
         BUS_TERMINATOR <= !mode_b_ff &&
            ((nxt_state == ARSQ_FULL_POWER) || (nxt_state == ARSQ_SUSPEND));
         LINEAR_UNDERVOLTAGE_MONITOR <= (nxt_state == ARSQ_FULL_POWER) ||
            (nxt_state == ARSQ_SUSPEND); // [RULE11]
      end
   end

   // ramp shaping hints to the analog side, fixed by mode
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         TERM_HALF_SLEW <= 1'b0;
         RAIL3_EARLY <= 1'b0;
      end else begin
         TERM_HALF_SLEW <= !mode_b_ff; // [RULE16]
         RAIL3_EARLY <= mode_b_ff; // [RULE15]
      end
   end

   // power-good pulled low on fault; released otherwise
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         POWER_GOOD_LINE_OUT <= 1'b0;
         POWER_GOOD_LINE_OE <= 1'b0;
      end else begin
         POWER_GOOD_LINE_OUT <= 1'b0;
         POWER_GOOD_LINE_OE <= fault; // [RULE13]
      end
   end

   // apb: zero-wait slave, access answered in its first access cycle
   assign apb_wr = PSEL && PENABLE && PWRITE;
   assign apb_rd = PSEL && !PENABLE && !PWRITE;

   function automatic logic addr_known(input logic [11:0] a);
      return (a == `ARSQ_OFF_CTRL) || (a == `ARSQ_OFF_STATUS) ||
         (a == `ARSQ_OFF_IRQ_STAT) || (a == `ARSQ_OFF_IRQ_MASK) || (a == `ARSQ_OFF_TRIM);
   endfunction

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         ctrl_ff <= `ARSQ_CTRL_RESET;
         irq_mask_ff <= '0;
      end else if (apb_wr) begin
         if (PADDR == `ARSQ_OFF_CTRL)
            ctrl_ff <= PWDATA;
         if (PADDR == `ARSQ_OFF_IRQ_MASK)
            irq_mask_ff <= PWDATA[`ARSQ_IRQ_W-1:0];
      end
   end

   // read data is set up in the setup cycle, so it stands at the access edge
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         PRDATA <= '0;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= PSEL && !PENABLE;
         PSLVERR <= PSEL && !PENABLE && !addr_known(PADDR);
         if (apb_rd) begin
            case (PADDR)
               `ARSQ_OFF_CTRL: PRDATA <= ctrl_ff;
               `ARSQ_OFF_STATUS: PRDATA <= {19'h0, mode_b_ff, ramping_ff, pg_s, sleep_s,
                  soft_off_s, dual_en_s, 2'h0, state_ff};
               // an event landing on the setup edge is read now, else the clear drops it
               `ARSQ_OFF_IRQ_STAT: PRDATA <= {29'h0, irq_stat_ff | ev};
               `ARSQ_OFF_IRQ_MASK: PRDATA <= {29'h0, irq_mask_ff};
               `ARSQ_OFF_TRIM: PRDATA <= {26'h0, TERM_TRIM, RAIL2_TRIM, RAIL1_TRIM};
               default: PRDATA <= '0;
            endcase
         end
      end
   end

   // sticky events; read-clear loses to a new event in the same cycle
   always_comb begin
      ev = '0;
      ev[`ARSQ_IRQ_STATE_CHG] = (nxt_state != state_ff);
      ev[`ARSQ_IRQ_FAULT] = fault;
      ev[`ARSQ_IRQ_WAKE_BLOCKED] = (state_ff == ARSQ_SUSPEND) && sleep_s && soft_off_s && !pg_s;
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST)
         irq_stat_ff <= '0;
      else if (PSEL && PENABLE && !PWRITE && PADDR == `ARSQ_OFF_IRQ_STAT)
         irq_stat_ff <= ev;
      else
         irq_stat_ff <= irq_stat_ff | ev;
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST)
         IRQ <= 1'b0;
      else
         IRQ <= |((irq_stat_ff | ev) & irq_mask_ff);
   end
endmodule // arsq_sequencer

// >>> arsq_sequencer_assertions.sv
// watches the sequencer outputs against the state map and the ramp and power-good gating
module arsq_sequencer_assertions (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // analog and wire inputs
   input wire logic RAMP_DONE,
   input wire logic OVER_CURRENT,
   input wire logic POWER_GOOD_LINE_IN,
   // power outputs
   input wire logic STANDBY_GATE_DRIVE,
   input wire logic MAIN_GATE_DRIVE,
   input wire logic LINEAR_RAIL_1,
   input wire logic LINEAR_RAIL_2,
   input wire logic BUS_TERMINATOR,
   input wire logic LINEAR_UNDERVOLTAGE_MONITOR,
   input wire logic POWER_GOOD_LINE_OE,
   // mode and trim outputs
   input wire logic TERM_HALF_SLEW,
   input wire logic RAIL3_EARLY,
   input wire logic [1:0] RAIL1_TRIM,
   input wire logic [1:0] TERM_TRIM
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RST);

   // two sync flops plus the output flop: the state moved on the input seen three edges back
   chk_gate_excl: assert property (!(STANDBY_GATE_DRIVE && MAIN_GATE_DRIVE))
      else $error("both gate drives on");
   chk_rail_gated: assert property (LINEAR_RAIL_1 |-> STANDBY_GATE_DRIVE || MAIN_GATE_DRIVE)
      else $error("rail on without dual rail");
   chk_full_map: assert property (MAIN_GATE_DRIVE |-> LINEAR_RAIL_1 &&
      BUS_TERMINATOR == TERM_HALF_SLEW && LINEAR_RAIL_2 != TERM_HALF_SLEW)
      else $error("full power output map wrong");
   chk_monitor_states: assert property (LINEAR_UNDERVOLTAGE_MONITOR ==
      (MAIN_GATE_DRIVE || (STANDBY_GATE_DRIVE && LINEAR_RAIL_1)))
      else $error("monitor outside full and suspend");
   chk_mode_excl: assert property (RAIL3_EARLY |-> !TERM_HALF_SLEW && !BUS_TERMINATOR)
      else $error("mode b shows terminator");
   chk_term_track: assert property (TERM_HALF_SLEW |-> TERM_TRIM == RAIL1_TRIM)
      else $error("terminator trim not half of rail 1");
   chk_ramp_gate: assert property (($rose(STANDBY_GATE_DRIVE) && !LINEAR_RAIL_1)
      || $rose(LINEAR_RAIL_1) |-> $past(RAMP_DONE, 3))
      else $error("ramped move before soft-start done");
   chk_wake_pg: assert property ($rose(MAIN_GATE_DRIVE) && $past(LINEAR_RAIL_1)
      |-> $past(POWER_GOOD_LINE_IN, 3))
      else $error("wake without power good");
   chk_pg_cause: assert property (POWER_GOOD_LINE_OE |-> $past(OVER_CURRENT)
      || $past(OVER_CURRENT, 2) || $past(OVER_CURRENT, 3) || $past(OVER_CURRENT, 4))
      else $error("power good pulled without over-current");
endmodule // arsq_sequencer_assertions

// >>> arsq_chipset_model.sv
// stands in for the system chipset: state lines and the shared power-good wire
module arsq_chipset_model (
   // clock
   input wire logic clk,
   // requested state: 0 full power, 1 suspend, 2 soft off
   input wire logic [1:0] req,
   // power-good wire parties
   input wire logic pg_low,
   input wire logic dev_oe,
   input wire logic dev_out,
   output logic pg_line,
   // state lines, active low
   output logic sleep_line_n,
   output logic soft_off_line_n
);
   timeunit 1ns;
   timeprecision 1ns;
   // undriven lines sit high on their pull-ups
   initial begin
      sleep_line_n = 1'b1;
      soft_off_line_n = 1'b1;
   end
   // requests move just after an edge, like a clocked chipset
   always @(posedge clk) begin
      sleep_line_n <= (req == 2'h0);
      soft_off_line_n <= (req != 2'h2);
   end
   // open-drain wire with pull-up: either party may pull it low
   assign pg_line = ~((dev_oe & ~dev_out) | pg_low);
endmodule // arsq_chipset_model

// >>> arsq_sequencer_tb.sv
`include "arsq_consts.svh"
module arsq_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int RAMP_LEN = 20;
   logic CLK_SYS = 1'b0;
   logic RST = 1'b1;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0000_0000;
   logic DUAL_RAIL_ENABLE_N = 1'b1;
   logic MODE_STRAP = 1'b0;
   logic [1:0] TRIM_STRAP = 2'h0;
   logic SUPPLY_QUALIFIED = 1'b0;
   logic [2:0] RAIL_UNDERVOLTAGE = 3'h0;
   logic OVER_CURRENT = 1'b0;
   logic [1:0] req = 2'h2;
   logic pg_low = 1'b0;
   logic ramp_hold = 1'b0;
   int ramp_cnt = 0;
   int miscompares = 0;
   int n_checks = 0;
   logic [31:0] rd, PRDATA;
   logic err, PREADY, PSLVERR, RAMP_DONE, SLEEP_LINE_N, SOFT_OFF_LINE_N, POWER_GOOD_LINE_IN;
   logic POWER_GOOD_LINE_OUT, POWER_GOOD_LINE_OE, STANDBY_GATE_DRIVE, MAIN_GATE_DRIVE, IRQ;
   logic LINEAR_RAIL_1, LINEAR_RAIL_2, LINEAR_RAIL_3, BUS_TERMINATOR, RAMP_RESTART;
   logic LINEAR_UNDERVOLTAGE_MONITOR, TERM_HALF_SLEW, RAIL3_EARLY;
   logic [1:0] RAIL1_TRIM, RAIL2_TRIM, TERM_TRIM;

   always #5 CLK_SYS = ~CLK_SYS;
   // soft-start node: restarts on request, hold freezes it to model a slow ramp
   always @(posedge CLK_SYS) begin
      if (RAMP_RESTART) ramp_cnt <= 0;
      else if (!ramp_hold && ramp_cnt < RAMP_LEN) ramp_cnt <= ramp_cnt + 1;
   end
   assign RAMP_DONE = (ramp_cnt == RAMP_LEN);

   arsq_sequencer u_arsq_sequencer (.CLK_SYS, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
      .PWDATA, .PRDATA, .PREADY, .PSLVERR, .SLEEP_LINE_N, .SOFT_OFF_LINE_N,
      .DUAL_RAIL_ENABLE_N, .MODE_STRAP, .TRIM_STRAP, .SUPPLY_QUALIFIED, .RAMP_DONE,
      .RAIL_UNDERVOLTAGE, .OVER_CURRENT, .POWER_GOOD_LINE_IN, .POWER_GOOD_LINE_OUT,
      .POWER_GOOD_LINE_OE, .STANDBY_GATE_DRIVE, .MAIN_GATE_DRIVE, .LINEAR_RAIL_1,
      .LINEAR_RAIL_2, .LINEAR_RAIL_3, .BUS_TERMINATOR, .LINEAR_UNDERVOLTAGE_MONITOR,
      .RAMP_RESTART, .TERM_HALF_SLEW, .RAIL3_EARLY, .RAIL1_TRIM, .RAIL2_TRIM, .TERM_TRIM, .IRQ);
   arsq_chipset_model u_arsq_chipset_model (.clk(CLK_SYS), .req(req), .pg_low(pg_low),
      .dev_oe(POWER_GOOD_LINE_OE), .dev_out(POWER_GOOD_LINE_OUT), .pg_line(POWER_GOOD_LINE_IN),
      .sleep_line_n(SLEEP_LINE_N), .soft_off_line_n(SOFT_OFF_LINE_N));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge CLK_SYS);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= wd;
      @(posedge CLK_SYS);
      PENABLE <= 1'b1;
      do @(posedge CLK_SYS); while (PREADY !== 1'b1);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   // expected {standby, main, rail 1, monitor} per one-hot state
   function automatic logic [3:0] out_map(input logic [4:0] st);
      case (st)
         5'h04: return 4'h8;
         5'h08: return 4'h7;
         5'h10: return 4'hb;
         default: return 4'h0;
      endcase
   endfunction
   // polls the state until it arrives, then checks the output map for the strapped mode
   task automatic reach(input logic [4:0] st);
      int i;
      logic [3:0] exp_map;
      i = 0;
      do begin
         apb(1'b0, `ARSQ_OFF_STATUS, 32'h0);
         i++;
      end while (rd[4:0] !== st && i < 200);
      check(rd[4:0], st);
      check({STANDBY_GATE_DRIVE, MAIN_GATE_DRIVE, LINEAR_RAIL_1, LINEAR_UNDERVOLTAGE_MONITOR},
         out_map(st));
      exp_map = out_map(st);
      // rails 2 and 3 belong to mode b, the terminator to mode a
      check({LINEAR_RAIL_2, LINEAR_RAIL_3, BUS_TERMINATOR},
         {3{exp_map[1]}} & (MODE_STRAP ? 3'b110 : 3'b001));
   endtask
   task automatic do_reset(input logic m, input logic [1:0] t);
      RST <= 1'b1;
      MODE_STRAP <= m;
      TRIM_STRAP <= t;
      repeat (10) @(posedge CLK_SYS);
      RST <= 1'b0;
      repeat (3) @(posedge CLK_SYS);
   endtask
   task automatic close_out();
      if (miscompares == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      // strap decode for both modes and every trim level
      for (int m = 0; m < 2; m++) begin
         for (int t = 0; t < 3; t++) begin
            do_reset(m[0], t[1:0]);
            check(TERM_HALF_SLEW, !m[0]);
            check(RAIL3_EARLY, m[0]);
            check(RAIL1_TRIM, m ? 2 - t : t);
            if (m) check(RAIL2_TRIM, 2 - t);
            else check(TERM_TRIM, t);
         end
      end
      do_reset(1'b0, 2'h1);
      repeat (20) @(posedge CLK_SYS);
      reach(5'h01);
      apb(1'b0, 12'h020, 32'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
      apb(1'b1, `ARSQ_OFF_IRQ_MASK, 32'h1);
      SUPPLY_QUALIFIED <= 1'b1;
      reach(5'h02);
      check(IRQ, 1'b1);
      apb(1'b0, `ARSQ_OFF_IRQ_STAT, 32'h0);
      check(rd[0], 1'b1);
      repeat (2) @(posedge CLK_SYS);
      check(IRQ, 1'b0);
      apb(1'b1, `ARSQ_OFF_IRQ_MASK, 32'h0);
      // a stalled ramp must keep the dual rail off
      ramp_hold <= 1'b1;
      DUAL_RAIL_ENABLE_N <= 1'b0;
      repeat (40) @(posedge CLK_SYS);
      check(STANDBY_GATE_DRIVE, 1'b0);
      ramp_hold <= 1'b0;
      reach(5'h04);
      check(IRQ, 1'b0);
      DUAL_RAIL_ENABLE_N <= 1'b1;
      reach(5'h02);
      req <= 2'h0;
      reach(5'h04);
      DUAL_RAIL_ENABLE_N <= 1'b0;
      reach(5'h08);
      // over-current on an unmonitored rail, then on rail 1
      OVER_CURRENT <= 1'b1;
      RAIL_UNDERVOLTAGE <= 3'h2;
      repeat (6) @(posedge CLK_SYS);
      check(POWER_GOOD_LINE_OE, 1'b0);
      RAIL_UNDERVOLTAGE <= 3'h1;
      repeat (6) @(posedge CLK_SYS);
      check(POWER_GOOD_LINE_IN, 1'b0);
      check(POWER_GOOD_LINE_OE, 1'b1);
      check(POWER_GOOD_LINE_OUT, 1'b0);
      OVER_CURRENT <= 1'b0;
      RAIL_UNDERVOLTAGE <= 3'h0;
      reach(5'h08);
      req <= 2'h1;
      reach(5'h10);
      pg_low <= 1'b1;
      req <= 2'h0;
      repeat (40) @(posedge CLK_SYS);
      reach(5'h10);
      // blocked wake and the earlier fault both left sticky bits
      apb(1'b0, `ARSQ_OFF_IRQ_STAT, 32'h0);
      check(rd[2:1], 2'h3);
      pg_low <= 1'b0;
      reach(5'h08);
      DUAL_RAIL_ENABLE_N <= 1'b1;
      req <= 2'h1;
      reach(5'h10);
      req <= 2'h2;
      reach(5'h02);
      // mode b climbs to full power with all three linear rails, any rail may fault
      do_reset(1'b1, 2'h1);
      req <= 2'h0;
      reach(5'h08);
      OVER_CURRENT <= 1'b1;
      RAIL_UNDERVOLTAGE <= 3'h4;
      repeat (6) @(posedge CLK_SYS);
      check(POWER_GOOD_LINE_OE, 1'b1);
      OVER_CURRENT <= 1'b0;
      RAIL_UNDERVOLTAGE <= 3'h0;
      close_out();
   end
   // cuts a hang short, well beyond the length of the sequence
   initial begin
      repeat (60000) @(posedge CLK_SYS);
      miscompares++;
      close_out();
   end
endmodule // arsq_sequencer_tb

bind arsq_sequencer arsq_sequencer_assertions u_arsq_sequencer_assertions (.CLK_SYS, .RST,
   .RAMP_DONE, .OVER_CURRENT, .POWER_GOOD_LINE_IN, .STANDBY_GATE_DRIVE, .MAIN_GATE_DRIVE,
   .LINEAR_RAIL_1, .LINEAR_RAIL_2, .BUS_TERMINATOR, .LINEAR_UNDERVOLTAGE_MONITOR,
   .POWER_GOOD_LINE_OE, .TERM_HALF_SLEW, .RAIL3_EARLY, .RAIL1_TRIM, .TERM_TRIM);
